// [core/acs_clk_div.v]
// Conversion clock divider: one-cycle enable every divisor pclk cycles.
// Assumes the caller holds run low to restart the count from one.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"

module acs_clk_div #(
   parameter W = `ACS_PRESC_W
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Control
   input wire run,
   input wire [W-1:0] divisor,
   // Enable out
   output reg tick
);

   reg [W-1:0] cnt;
   wire [W-1:0] last;

   // A divisor of zero behaves as one
   assign last = (divisor == {W{1'b0}}) ? {W{1'b0}} : divisor - {{(W-1){1'b0}}, 1'b1};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= {W{1'b0}};
         tick <= 1'b0;
      end else if (!run) begin
         // Preload one so the registered tick lands P cycles after run rises
         cnt <= {{(W-1){1'b0}}, 1'b1};
         tick <= 1'b0;
      end else if (cnt >= last) begin
         cnt <= {W{1'b0}};
         tick <= 1'b1;
      end else begin
         cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [core/acs_defines.vh]
// Constants for the conversion sequencer: register indices, fields,
// reset values and timing. Included by every file of the block.
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// Register indices; byte address is four times the index
`define ACS_IDX_CTL 14'h0f70
`define ACS_IDX_DATA_H 14'h0f72
`define ACS_IDX_DATA_L 14'h0f73
`define ACS_IDX_SETTLE 14'h0f74
`define ACS_IDX_SAMPLE 14'h0f75
`define ACS_IDX_PRESCALE 14'h0f76

// Control register fields
`define ACS_START_BIT 7
`define ACS_REFERENCE_BUFFER_ENABLE_BIT 5
`define ACS_EN_BIT 4
`define ACS_CHAN_MSB 2
`define ACS_CHAN_LSB 0

// Field widths
`define ACS_RES_W 10
`define ACS_SETTLE_W 4
`define ACS_SAMPLE_W 8
`define ACS_PRESC_W 8

// Low bits register: two result LSBs in the top of the byte
`define ACS_LOW_MSB 7
`define ACS_LOW_LSB 6

// Timing
`define ACS_CLK_PERIOD_NS 20
`define ACS_SAMPLE_MIN_NS 1000
`define ACS_SAMPLE_MIN_CYC ((`ACS_SAMPLE_MIN_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_CONV_TICKS 13
`define ACS_SAR_STEPS 10

// Reset values
`define ACS_SETTLE_RST 4'h7
`define ACS_SAMPLE_RST 8'h32
`define ACS_PRESC_RST 8'h05
`define ACS_TRIAL_MSB 10'h200

// Sequencer states
`define ACS_ST_IDLE 2'h0
`define ACS_ST_SAMPLE 2'h1
`define ACS_ST_SETTLE 2'h2
`define ACS_ST_CONVERT 2'h3

`endif

// [core/acs_sar.v]
// Successive approximation register with comparator synchroniser.
// Assumes the comparator settles within one conversion clock period
// less four pclk cycles of synchroniser and agreement delay.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"

module acs_sar (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Sequencing
   input wire run,
   input wire tick,
   // Comparator, asynchronous
   input wire comparator_in,
   // Trial code and completion
   output reg [`ACS_RES_W-1:0] trial,
   output wire done
);

   reg sync1;
   reg sync2;
   reg sync3;
   reg comp_level;
   reg [`ACS_RES_W-1:0] mask;
   reg [3:0] tick_cnt;

   assign done = run & tick & (tick_cnt == `ACS_CONV_TICKS - 1);

   // Comparator level counts only once two stages agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         comp_level <= 1'b0;
      end else begin
         sync1 <= comparator_in;
         sync2 <= sync1;
         sync3 <= sync2;
         if (sync2 == sync3) begin
            comp_level <= sync3;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trial <= `ACS_TRIAL_MSB;
         mask <= `ACS_TRIAL_MSB;
         tick_cnt <= 4'h0;
      end else if (!run) begin
         trial <= `ACS_TRIAL_MSB;
         mask <= `ACS_TRIAL_MSB;
         tick_cnt <= 4'h0;
      end else if (tick) begin
         tick_cnt <= tick_cnt + 4'h1;
         if (tick_cnt < `ACS_SAR_STEPS) begin
            // Bits only ever settle from the top down, so a comparator stuck
            // low ends at zero and stuck high at full scale: no wrap
            trial <= (comp_level ? trial : (trial & ~mask)) | (mask >> 1);
            mask <= mask >> 1;
         end
      end
   end

endmodule
`default_nettype wire

// [core/acs_sequencer.v]
// Conversion sequencer for an eight-channel SAR converter, APB slave.
// Assumes an analog core with input mux, sample-and-hold and a
// comparator that reports whether the input lies above trial_code.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"

module acs_sequencer #(
   parameter ADDR_W = 16
) (
   // APB clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Analog core
   input wire comparator_in,
   output reg [2:0] channel_select,
   output wire sample_hold,
   output wire converter_enable,
   output wire reference_buffer_enable,
   output wire [`ACS_RES_W-1:0] trial_code,
   output wire conversion_clock,
   // Completion request to the interrupt controller
   output reg conversion_done
);

   // Configuration and state
   reg ctl_en;
   reg ctl_reference_buffer_enable;
   reg [2:0] ctl_chan;
   reg [`ACS_SETTLE_W-1:0] settle_time_count;
   reg [`ACS_SAMPLE_W-1:0] sample_time_count;
   reg [`ACS_PRESC_W-1:0] conversion_prescale;
   reg [`ACS_RES_W-1:0] result;
   reg [1:0] low_bits;
   reg [1:0] state;
   reg [`ACS_SAMPLE_W-1:0] phase_cnt;

   // Address decode
   wire [ADDR_W-3:0] word_idx;
   wire sel_ctl;
   wire sel_data_h;
   wire sel_data_l;
   wire sel_settle;
   wire sel_sample;
   wire sel_presc;
   wire mapped;
   wire setup_rd;
   wire wr_en;
   wire start_req;
   wire next_en;
   wire busy;
   wire conv_run;
   wire conv_tick;
   wire sar_done;
   wire phase_last;
   reg [31:0] next_rdata;

   assign word_idx = paddr[ADDR_W-1:2];
   assign sel_ctl = (word_idx == `ACS_IDX_CTL) && (paddr[1:0] == 2'h0);
   assign sel_data_h = (word_idx == `ACS_IDX_DATA_H) && (paddr[1:0] == 2'h0);
   assign sel_data_l = (word_idx == `ACS_IDX_DATA_L) && (paddr[1:0] == 2'h0);
   assign sel_settle = (word_idx == `ACS_IDX_SETTLE) && (paddr[1:0] == 2'h0);
   assign sel_sample = (word_idx == `ACS_IDX_SAMPLE) && (paddr[1:0] == 2'h0);
   assign sel_presc = (word_idx == `ACS_IDX_PRESCALE) && (paddr[1:0] == 2'h0);
   assign mapped = sel_ctl | sel_data_h | sel_data_l | sel_settle | sel_sample | sel_presc;

   // Zero wait states: every access phase completes at once
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   assign setup_rd = psel & ~penable & ~pwrite;
   assign wr_en = psel & penable & pwrite & mapped;

   // A start written together with the enable bit is honoured
   assign next_en = pwdata[`ACS_EN_BIT];
   assign start_req = wr_en & sel_ctl & pwdata[`ACS_START_BIT] & next_en;

   assign busy = (state != `ACS_ST_IDLE);
   // A restart clears divider and trial code at once, before sampling shows
   assign conv_run = (state == `ACS_ST_CONVERT) & ~start_req;
   assign phase_last = (phase_cnt <= {{(`ACS_SAMPLE_W-1){1'b0}}, 1'b1});

   // Analog controls
   assign sample_hold = (state == `ACS_ST_SAMPLE);
   assign converter_enable = ctl_en;
   assign reference_buffer_enable = ctl_reference_buffer_enable;
   assign conversion_clock = conv_tick;

   acs_clk_div #(
      .W(`ACS_PRESC_W)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(conv_run),
      .divisor(conversion_prescale),
      .tick(conv_tick)
   );

   acs_sar u_sar (
      .pclk(pclk),
      .presetn(presetn),
      .run(conv_run),
      .tick(conv_tick),
      .comparator_in(comparator_in),
      .trial(trial_code),
      .done(sar_done)
   );

   // Register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_en <= 1'b0;
         ctl_reference_buffer_enable <= 1'b0;
         ctl_chan <= 3'h0;
         settle_time_count <= `ACS_SETTLE_RST;
         sample_time_count <= `ACS_SAMPLE_RST;
         conversion_prescale <= `ACS_PRESC_RST;
      end else if (wr_en) begin
         if (sel_ctl) begin
            ctl_en <= next_en;
            ctl_reference_buffer_enable <= pwdata[`ACS_REFERENCE_BUFFER_ENABLE_BIT];
            ctl_chan <= pwdata[`ACS_CHAN_MSB:`ACS_CHAN_LSB];
         end
         if (sel_settle) begin
            settle_time_count <= pwdata[`ACS_SETTLE_W-1:0];
         end
         if (sel_sample) begin
            sample_time_count <= pwdata[`ACS_SAMPLE_W-1:0];
         end
         if (sel_presc) begin
            conversion_prescale <= pwdata[`ACS_PRESC_W-1:0];
         end
      end
   end

   // Phase sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= `ACS_ST_IDLE;
         phase_cnt <= {`ACS_SAMPLE_W{1'b0}};
         channel_select <= 3'h0;
         result <= {`ACS_RES_W{1'b0}};
         conversion_done <= 1'b0;
      end else begin
         conversion_done <= 1'b0;
         if (start_req) begin
            // Any running conversion is dropped without a request
            state <= `ACS_ST_SAMPLE;
            phase_cnt <= sample_time_count;
            channel_select <= pwdata[`ACS_CHAN_MSB:`ACS_CHAN_LSB];
         end else if (!ctl_en || (wr_en && sel_ctl && !next_en)) begin
            state <= `ACS_ST_IDLE;
         end else begin
            case (state)
               `ACS_ST_IDLE: begin
                  state <= `ACS_ST_IDLE;
               end
               `ACS_ST_SAMPLE: begin
                  if (phase_last) begin
                     state <= `ACS_ST_SETTLE;
                     phase_cnt <= {{(`ACS_SAMPLE_W-`ACS_SETTLE_W){1'b0}},
                                   settle_time_count};
                  end else begin
                     phase_cnt <= phase_cnt - {{(`ACS_SAMPLE_W-1){1'b0}}, 1'b1};
                  end
               end
               `ACS_ST_SETTLE: begin
                  if (phase_last) begin
                     state <= `ACS_ST_CONVERT;
                  end else begin
                     phase_cnt <= phase_cnt - {{(`ACS_SAMPLE_W-1){1'b0}}, 1'b1};
                  end
               end
               `ACS_ST_CONVERT: begin
                  if (sar_done) begin
                     state <= `ACS_ST_IDLE;
                     result <= trial_code;
                     // Pulse lands in the first idle cycle; a later disable
                     // cannot take back a request already handed over
                     conversion_done <= 1'b1;
                  end
               end
               default: begin
                  state <= `ACS_ST_IDLE;
               end
            endcase
         end
      end
   end

   // Low bits follow the high byte read so both halves match
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_bits <= 2'h0;
      end else if (setup_rd && sel_data_h) begin
         low_bits <= result[1:0];
      end
   end

   // Read data, captured in the setup cycle
   always @* begin
      next_rdata = 32'h0000_0000;
      if (sel_ctl) begin
         next_rdata[`ACS_START_BIT] = busy;
         next_rdata[`ACS_REFERENCE_BUFFER_ENABLE_BIT] = ctl_reference_buffer_enable;
         next_rdata[`ACS_EN_BIT] = ctl_en;
         next_rdata[`ACS_CHAN_MSB:`ACS_CHAN_LSB] = ctl_chan;
      end
      if (sel_data_h) begin
         next_rdata[7:0] = result[`ACS_RES_W-1:2];
      end
      if (sel_data_l) begin
         next_rdata[`ACS_LOW_MSB:`ACS_LOW_LSB] = low_bits;
      end
      if (sel_settle) begin
         next_rdata[`ACS_SETTLE_W-1:0] = settle_time_count;
      end
      if (sel_sample) begin
         next_rdata[`ACS_SAMPLE_W-1:0] = sample_time_count;
      end
      if (sel_presc) begin
         next_rdata[`ACS_PRESC_W-1:0] = conversion_prescale;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata <= next_rdata;
      end
   end

endmodule
`default_nettype wire

// [sim/acs_analog_model.sv]
// Analog side: channel mux, sample-and-hold and comparator.
// Levels are in quarter LSB; the bench writes lvl directly.
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
   // From the sequencer
   input wire logic [2:0] channel_select,
   input wire logic sample_hold,
   input wire logic [9:0] trial_code,
   // To the sequencer
   output logic comparator_in
);
   int lvl [8];
   int held = 0;
   always @* begin
      if (sample_hold) begin
         held = lvl[channel_select];
      end
   end
   // No offset here; the bench's half-LSB level offset keeps decisions off the threshold
   assign comparator_in = held > 4 * int'(trial_code);
endmodule
`default_nettype wire

// [sim/acs_checker.sv]
// Port-level checks of the conversion sequencer.
// Assumes the bind below and byte addresses of four times the index.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"
module acs_checker #(
   parameter ADDR_W = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   // Analog side
   input wire logic [2:0] channel_select,
   input wire logic sample_hold,
   input wire logic converter_enable,
   input wire logic reference_buffer_enable,
   input wire logic [`ACS_RES_W-1:0] trial_code,
   input wire logic conversion_clock,
   input wire logic conversion_done
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic ctl_wr = psel && penable && pwrite && paddr == {`ACS_IDX_CTL, 2'b00};
   wire logic start = ctl_wr && pwdata[7] && pwdata[4];
   start_restart_a: assert property (start |=> sample_hold && !conversion_done)
      else $error("start did not restart sampling");
   start_only_a: assert property ($rose(sample_hold) |-> $past(start))
      else $error("sampling began without a start write");
   disable_stop_a: assert property (ctl_wr && !pwdata[4] |=> !sample_hold ##1
      !conversion_clock [*4]) else $error("disable left converter running");
   done_pulse_a: assert property (conversion_done |=> !conversion_done)
      else $error("done longer than one cycle");
   sample_idle_a: assert property (sample_hold |-> !conversion_clock &&
      trial_code == `ACS_TRIAL_MSB) else $error("conversion during sampling");
   chan_latch_a: assert property ($changed(channel_select) |-> $past(start))
      else $error("channel changed without start");
   done_gap_a: assert property (conversion_done |-> !$past(sample_hold) &&
      !$past(sample_hold, 14)) else $error("conversion too short");
   enable_bits_a: assert property ($changed({converter_enable, reference_buffer_enable})
      |-> $past(ctl_wr) && {converter_enable, reference_buffer_enable} ==
      $past({pwdata[4], pwdata[5]})) else $error("enable bits wrong");
endmodule
bind acs_sequencer acs_checker #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .channel_select(channel_select), .sample_hold(sample_hold),
   .converter_enable(converter_enable), .reference_buffer_enable(reference_buffer_enable),
   .trial_code(trial_code), .conversion_clock(conversion_clock),
   .conversion_done(conversion_done));
`default_nettype wire

// [sim/tb.sv]
// Bench for the conversion sequencer: APB master, analog model, queued done checks.
// Assumes the defines header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"
module tb;
   localparam logic [15:0] A_CTL = {`ACS_IDX_CTL, 2'b00};
   localparam logic [15:0] A_DH = {`ACS_IDX_DATA_H, 2'b00};
   localparam logic [15:0] A_DL = {`ACS_IDX_DATA_L, 2'b00};
   localparam logic [15:0] A_SET = {`ACS_IDX_SETTLE, 2'b00};
   localparam logic [15:0] A_SMP = {`ACS_IDX_SAMPLE, 2'b00};
   localparam logic [15:0] A_PRE = {`ACS_IDX_PRESCALE, 2'b00};
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [15:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, seed = 32'h6425;
   logic pready, pslverr, err, cmp, sh, en, rfe, cclk, done;
   logic [2:0] ch;
   logic [9:0] trial, last = 0;
   int mismatches = 0, samples_checked = 0, cyc = 0, eacc = 0;
   int exp_q[$];
   logic [15:0] ra [6] = '{A_CTL, A_DH, A_DL, A_SET, A_SMP, A_PRE};
   logic [31:0] rv [6] = '{0, 0, 0, 7, 32'h32, 5};
   acs_sequencer #(.ADDR_W(16)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparator_in(cmp),
      .channel_select(ch), .sample_hold(sh), .converter_enable(en),
      .reference_buffer_enable(rfe), .trial_code(trial), .conversion_clock(cclk),
      .conversion_done(done));
   acs_analog_model i_ana (.channel_select(ch), .sample_hold(sh), .trial_code(trial),
      .comparator_in(cmp));
   always #10 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      eacc = cyc;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic conv(input logic [2:0] c, input int k);
      logic [31:0] s, h, p;
      logic [9:0] r;
      s = (rnd() & 7) + 1;
      h = (rnd() & 3) + 1;
      // Synchroniser plus agreement stage needs five pclk per decision
      p = (rnd() & 3) + 5;
      r = k < 0 ? 10'h0 : (k > 4095 ? 10'h3ff : 10'(k / 4));
      i_ana.lvl[c] = k;
      apb(1, A_SMP, s);
      apb(1, A_SET, h);
      apb(1, A_PRE, p);
      apb(1, A_CTL, 32'h90 | c);
      exp_q.push_back((eacc + s + h + 13 * p + 1) * 8 + c);
      apb(0, A_CTL, 0);
      check(rd, 32'h90 | c);
      repeat (s + h + 13 * p) @(posedge pclk);
      apb(0, A_CTL, 0);
      check(rd, 32'h10 | c);
      apb(0, A_DL, 0);
      check(rd, {24'h0, last[1:0], 6'h0});
      apb(0, A_DH, 0);
      check(rd, {24'h0, r[9:2]});
      apb(0, A_DL, 0);
      check(rd, {24'h0, r[1:0], 6'h0});
      last = r;
   endtask
   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Any done pulse must match the oldest pending start
   always @(posedge pclk) begin
      if (presetn && done === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(1, 0);
         end else begin
            check(cyc * 8 + ch, exp_q.pop_front());
         end
      end
   end
   initial begin
      #1_000_000;
      mismatches++;
      results();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++) begin
         apb(0, ra[i], 0);
         check(rd, rv[i]);
      end
      apb(0, 16'h3dc4, 0);
      check({err, rd}, {1'b1, 32'h0});
      for (int c = 0; c < 8; c++) begin
         conv(3'(c), c == 6 ? -40 : (c == 7 ? 5000 : int'(rnd() & 1023) * 4 + 2));
      end
      apb(1, A_CTL, 32'h91);
      repeat (3) @(posedge pclk);
      conv(2, 1234);
      apb(1, A_CTL, 32'h93);
      repeat (4) @(posedge pclk);
      apb(1, A_CTL, 32'h03);
      check(en, 0);
      repeat (200) @(posedge pclk);
      apb(0, A_DH, 0);
      check(rd, {24'h0, last[9:2]});
      apb(1, A_CTL, 32'h87);
      apb(0, A_CTL, 0);
      check(rd, 32'h07);
      apb(1, A_CTL, 32'h78);
      apb(0, A_CTL, 0);
      check(rd, 32'h30);
      check(rfe, 1);
      results();
   end
endmodule
`default_nettype wire
